// *** i2c_slave_defines.vh ***
/*
 * constants for the two-wire slave port: register byte addresses,
 * field positions, reset values and timing counts.
 * assumes it is included by bare name from the design file.
 */
`ifndef I2C_SLAVE_DEFINES_VH
`define I2C_SLAVE_DEFINES_VH

// register byte addresses
`define ADDR_MODE_CTRL 12'h000
`define ADDR_STATUS_CTRL 12'h004
`define ADDR_SHIFT_DATA 12'h008
`define ADDR_OWN_ADDR 12'h00C
`define ADDR_TIMEOUT_CTRL 12'h010
// status/control field positions
`define BIT_BYTE_DONE 7
`define BIT_ADDR_MATCH 6
`define BIT_BUS_BUSY 5
`define BIT_TX_SEL 4
`define BIT_ACK_OUT 3
`define BIT_MASTER_READ 2
`define BIT_CLOCKLESS 1
`define BIT_ACK_IN 0
// mode control fields
`define MODE_HI 7
`define MODE_LO 5
`define BIT_ENABLE 1
`define MODE_TWO_WIRE 3'h6
// timeout control fields
`define BIT_TO_EN 7
`define BIT_TO_FLAG 6
// reset values
`define RST_MODE_CTRL 8'hE0
`define RST_STATUS_CTRL 8'h81
`define RST_OWN_ADDR 8'h00
`define RST_TIMEOUT_CTRL 8'h00
// timing: timeout unit is 32 slow clock periods of 31.25 us = 1000 us
`define TO_UNIT_NS 1000000
`define CLK_NS 50
`define TO_UNIT_CYC (`TO_UNIT_NS / `CLK_NS)
`define BYTE_BITS 4'h8

`endif

// *** i2c_slave_serial_port.v ***
/*
 * two-wire slave port with byte shift register, own address match,
 * acknowledge control, clock stretching and a bus timeout, behind an
 * ahb-lite register slave.
 * assumes scl/sda pins arrive asynchronous and are open drain with
 * external pull-ups; the pad combines the enables into the wire.
 */
`include "i2c_slave_defines.vh"

module i2c_slave_serial_port #(
    parameter TO_UNIT = `TO_UNIT_CYC
) (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // ahb-lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // two-wire pins
    input wire scl_in,
    output reg scl_oe,
    input wire sda_in,
    output reg sda_oe,
    // serial interrupt request
    output reg serial_irq
);
    ////////////////////////////////////////////////////////////////////
    // states of the bit engine
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_RX = 3'h3;
    localparam ST_RACK = 3'h4;
    localparam ST_TX = 3'h5;
    localparam ST_TACK = 3'h6;
    localparam ST_WAIT = 3'h7;
    // last prescaler count of one timeout unit
    localparam [31:0] TO_LAST = TO_UNIT - 1;

    // registers
    reg [7:0] serial_mode_ctrl_reg; // mode field and enable
    reg byte_done_flag;
    reg addr_match_flag;
    reg bus_busy_flag;
    reg transmit_select;
    reg ack_out_bit;
    reg master_read_flag;
    reg clockless_run_select;
    reg ack_in_flag;
    reg [7:0] shift_data_reg;
    reg [6:0] own_address_bits;
    reg timeout_enable;
    reg timeout_flag;
    reg [5:0] timeout_sel;

    // synchronisers and debounce
    reg scl_s1, scl_s2, scl_d1, scl_db, sda_s1, sda_s2, sda_d;
    // engine state
    reg [2:0] state;
    reg [3:0] bit_cnt; // bits moved in the current byte
    reg stretch; // holding scl low for software
    reg [14:0] unit_cnt; // timeout prescaler
    reg [6:0] to_cnt; // timeout units elapsed
    // pending ahb address phase
    reg ph_wr, ph_rd;
    reg [11:0] ph_addr;
    reg en_q; // enable delayed for edge find

    ////////////////////////////////////////////////////////////////////
    // helpers
    function sel_addr;
        input [11:0] a;
        input [11:0] b;
        begin
            sel_addr = (a == b);
        end
    endfunction

    wire active = (serial_mode_ctrl_reg[`MODE_HI:`MODE_LO] == `MODE_TWO_WIRE) &&
        serial_mode_ctrl_reg[`BIT_ENABLE];
    wire scl_hi_now = scl_s2;
    wire scl_r = ~scl_db & scl_hi_now & scl_d1; // stable high two clocks
    wire scl_f = scl_db & ~scl_hi_now & ~scl_d1; // stable low two clocks
    wire start_det = scl_db & sda_d & ~sda_s2;
    wire stop_det = scl_db & ~sda_d & sda_s2;
    wire ahb_go = hsel & hready & htrans[1];
    wire wr_data = ph_wr & sel_addr(ph_addr, `ADDR_SHIFT_DATA);
    wire rd_data = ph_rd & sel_addr(ph_addr, `ADDR_SHIFT_DATA);
    wire to_hit = timeout_enable & (to_cnt > {1'b0, timeout_sel});
    wire [7:0] status_word = {byte_done_flag, addr_match_flag, bus_busy_flag,
        transmit_select, ack_out_bit, master_read_flag, clockless_run_select, ack_in_flag};

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers; scl accepted after two equal samples
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d1 <= 1'b1;
            scl_db <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_d1 <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
            // debounced level changes only after two agreeing clocks
            if (scl_s2 == scl_d1) begin
                scl_db <= scl_s2;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait, okay only
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_addr <= 12'h000;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            ph_wr <= ahb_go & hwrite;
            ph_rd <= ahb_go & ~hwrite;
            ph_addr <= haddr;
            // read data presented in the data phase
            if (ahb_go & ~hwrite) begin
                if (sel_addr(haddr, `ADDR_MODE_CTRL)) begin
                    hrdata <= {24'h000000, serial_mode_ctrl_reg};
                end else if (sel_addr(haddr, `ADDR_STATUS_CTRL)) begin
                    hrdata <= {24'h000000, status_word};
                end else if (sel_addr(haddr, `ADDR_SHIFT_DATA)) begin
                    hrdata <= {24'h000000, shift_data_reg};
                end else if (sel_addr(haddr, `ADDR_OWN_ADDR)) begin
                    hrdata <= {24'h000000, own_address_bits, 1'b0};
                end else if (sel_addr(haddr, `ADDR_TIMEOUT_CTRL)) begin
                    hrdata <= {24'h000000, timeout_enable, timeout_flag, timeout_sel};
                end else begin
                    hrdata <= 32'h00000000; // unmapped reads zero
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers and bit engine
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            serial_mode_ctrl_reg <= `RST_MODE_CTRL;
            {byte_done_flag, addr_match_flag, bus_busy_flag, transmit_select,
                ack_out_bit, master_read_flag, clockless_run_select,
                ack_in_flag} <= `RST_STATUS_CTRL;
            shift_data_reg <= 8'h00;
            own_address_bits <= 7'h00;
            {timeout_enable, timeout_flag, timeout_sel} <= `RST_TIMEOUT_CTRL;
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            stretch <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            serial_irq <= 1'b0;
            unit_cnt <= 15'h0000;
            to_cnt <= 7'h00;
            en_q <= 1'b0;
        end else begin
            serial_irq <= 1'b0;
            en_q <= serial_mode_ctrl_reg[`BIT_ENABLE];
            // software writes
            if (ph_wr) begin
                if (sel_addr(ph_addr, `ADDR_MODE_CTRL)) begin
                    serial_mode_ctrl_reg <= hwdata[7:0] & 8'hE2;
                end else if (sel_addr(ph_addr, `ADDR_STATUS_CTRL)) begin
                    transmit_select <= hwdata[`BIT_TX_SEL];
                    ack_out_bit <= hwdata[`BIT_ACK_OUT];
                    clockless_run_select <= hwdata[`BIT_CLOCKLESS];
                end else if (sel_addr(ph_addr, `ADDR_SHIFT_DATA)) begin
                    shift_data_reg <= hwdata[7:0];
                end else if (sel_addr(ph_addr, `ADDR_OWN_ADDR)) begin
                    own_address_bits <= hwdata[7:1];
                end else if (sel_addr(ph_addr, `ADDR_TIMEOUT_CTRL)) begin
                    timeout_enable <= hwdata[7];
                    timeout_flag <= hwdata[6];
                    timeout_sel <= hwdata[5:0];
                end
            end
            // software service ends the stretch; scl follows once data is set
            if (stretch & ((wr_data & transmit_select) | (rd_data & ~transmit_select))) begin
                stretch <= 1'b0;
            end
            // enable rising in two-wire mode: flags to defaults only
            if (active & ~en_q) begin
                byte_done_flag <= 1'b1;
                addr_match_flag <= 1'b0;
                bus_busy_flag <= 1'b0;
                master_read_flag <= 1'b0;
                ack_in_flag <= 1'b1;
            end
            if (!active) begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
                scl_oe <= 1'b0;
                stretch <= 1'b0;
            end else if (start_det) begin
                bus_busy_flag <= 1'b1;
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_det) begin
                bus_busy_flag <= 1'b0;
                state <= ST_IDLE;
                sda_oe <= 1'b0;
                scl_oe <= 1'b0;
                stretch <= 1'b0;
            end else if (scl_r) begin
                // sample data on rising scl
                case (state)
                    ST_ADDR, ST_RX: begin
                        shift_data_reg <= {shift_data_reg[6:0], sda_s2};
                        bit_cnt <= bit_cnt + 4'h1;
                        byte_done_flag <= 1'b0;
                    end
                    ST_TACK: begin
                        ack_in_flag <= sda_s2;
                    end
                endcase
            end else if (scl_f) begin
                // drive or release data on falling scl
                case (state)
                    ST_ADDR: begin
                        if (bit_cnt == `BYTE_BITS) begin
                            master_read_flag <= shift_data_reg[0];
                            if (shift_data_reg[7:1] == own_address_bits) begin
                                addr_match_flag <= 1'b1;
                                serial_irq <= 1'b1;
                                sda_oe <= 1'b1;
                                state <= ST_AACK;
                            end else begin
                                addr_match_flag <= 1'b0;
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK, ST_RACK: begin
                        // ack period over: wait, held while software must service
                        bit_cnt <= 4'h0;
                        sda_oe <= 1'b0;
                        state <= ST_WAIT;
                        if (state == ST_AACK | ~ack_out_bit) begin
                            stretch <= ~(clockless_run_select & ~transmit_select);
                            scl_oe <= ~(clockless_run_select & ~transmit_select);
                        end
                    end
                    ST_RX: begin
                        if (bit_cnt == `BYTE_BITS) begin
                            byte_done_flag <= 1'b1;
                            addr_match_flag <= 1'b0;
                            serial_irq <= 1'b1;
                            sda_oe <= ~ack_out_bit;
                            state <= ST_RACK;
                        end
                    end
                    ST_TX: begin
                        if (bit_cnt == `BYTE_BITS) begin
                            byte_done_flag <= 1'b1;
                            serial_irq <= 1'b1;
                            sda_oe <= 1'b0;
                            state <= ST_TACK;
                        end else begin
                            sda_oe <= ~shift_data_reg[3'h7 - bit_cnt[2:0]];
                            bit_cnt <= bit_cnt + 4'h1;
                            byte_done_flag <= 1'b0;
                        end
                    end
                    ST_TACK: begin
                        bit_cnt <= 4'h0;
                        if (ack_in_flag) begin
                            sda_oe <= 1'b0;
                            state <= ST_IDLE;
                        end else begin
                            stretch <= 1'b1;
                            scl_oe <= 1'b1;
                            state <= ST_WAIT;
                        end
                    end
                endcase
            end else if (state == ST_WAIT & ~stretch) begin
                // serviced: direction taken now that software has set it
                if (transmit_select) begin
                    sda_oe <= ~shift_data_reg[7]; // first bit while scl still low
                    bit_cnt <= 4'h1;
                    byte_done_flag <= 1'b0;
                    state <= ST_TX;
                end else begin
                    sda_oe <= 1'b0;
                    bit_cnt <= 4'h0;
                    state <= ST_RX;
                end
            end else if (scl_oe & ~stretch) begin
                // data settled a cycle before scl is let go
                scl_oe <= 1'b0;
            end
            // timeout: counts while the bus is busy and scl does not fall
            if (~timeout_enable | scl_f | stop_det | ~bus_busy_flag) begin
                unit_cnt <= 15'h0000;
                to_cnt <= 7'h00;
            end else if ({17'h00000, unit_cnt} == TO_LAST) begin
                unit_cnt <= 15'h0000;
                to_cnt <= to_cnt + 7'h01;
            end else begin
                unit_cnt <= unit_cnt + 15'h0001;
            end
            if (to_hit) begin
                timeout_enable <= 1'b0;
                timeout_flag <= 1'b1;
                serial_irq <= 1'b1;
                {byte_done_flag, addr_match_flag, bus_busy_flag, transmit_select,
                    ack_out_bit, master_read_flag, clockless_run_select,
                    ack_in_flag} <= `RST_STATUS_CTRL;
                state <= ST_IDLE;
                sda_oe <= 1'b0;
                scl_oe <= 1'b0;
                stretch <= 1'b0;
            end
        end
    end
endmodule

// *** i2c_slave_port_sva.sv ***
/* checker for the two-wire slave port.
   assumes a bind onto the port's top module. */
`include "i2c_slave_defines.vh"
module i2c_slave_port_sva #(
    parameter TO_UNIT = 20
) (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // register bus
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // pins and irq
    input wire scl_in,
    input wire scl_oe,
    input wire sda_in,
    input wire sda_oe,
    input wire serial_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    reg busy_seen; // start seen, no stop since
    reg sda_q; // sda one edge back
    reg scl_q; // scl one edge back
    reg [3:0] since_svc; // cycles since shift data access
    reg [6:0] since_irq; // cycles since irq
    wire acc = hsel && hready && htrans[1]; // access taken
    ////////////////////////////////////////
    // bus state from the pins, service distances
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busy_seen <= 1'h0;
            sda_q <= 1'h1;
            scl_q <= 1'h1;
            since_svc <= 4'hF;
            since_irq <= 7'h7F;
        end else begin
            sda_q <= sda_in;
            scl_q <= scl_in;
            // scl high at both samples, so data moved while scl stood high
            if (scl_q && scl_in && sda_q && !sda_in) begin
                busy_seen <= 1'h1;
            end else if (scl_q && scl_in && !sda_q && sda_in) begin
                busy_seen <= 1'h0;
            end
            if (acc && haddr == `ADDR_SHIFT_DATA) begin
                since_svc <= 4'h0;
            end else begin
                since_svc <= since_svc + {3'h0, since_svc != 4'hF};
            end
            since_irq <= serial_irq ? 7'h0 : since_irq + {6'h0, since_irq != 7'h7F};
        end
    end
    // irq drops the cycle after it rises
    sequence s_irq_end;
        ##1 !serial_irq;
    endsequence
    ////////////////////////////////////////
    a_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_irq_pulse: assert property ($rose(serial_irq) |-> s_irq_end)
        else $error("irq longer than one cycle");
    a_rdata_byte: assert property (acc && !hwrite |=> hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_own_bit0: assert property (acc && !hwrite && haddr == `ADDR_OWN_ADDR |=> !hrdata[0])
        else $error("own address bit 0 not zero");
    a_idle_quiet: assert property (!busy_seen |-> !sda_oe && !scl_oe)
        else $error("pin driven on idle bus");
    a_irq_busy: assert property (serial_irq |-> busy_seen)
        else $error("irq outside a frame");
    a_svc_release: assert property ($fell(scl_oe) |->
        since_svc <= 4'h5 || since_irq <= 7'h3 || serial_irq)
        else $error("clock released without service");
    a_stretch_cause: assert property ($rose(scl_oe) |-> since_irq <= 7'h3C)
        else $error("clock held without match or byte");
endmodule

// *** i2c_bus_master.sv ***
/* two-wire bus master model: start, stop, byte write and read.
   assumes open drain wires with pull-ups made by the bench. */
module i2c_bus_master (
    // wire levels
    input wire scl,
    input wire sda,
    // pull-down controls
    output logic scl_lo,
    output logic sda_lo
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int Q = 100; // quarter of the 400 ns period
    int stuck = 0; // stretch waits that ran out
    initial begin
        scl_lo = 1'h0;
        sda_lo = 1'h0;
    end
    ////////////////////////////////////////
    // step onto a 10 ns grid, clear of the bench clock's rising edges
    task automatic align;
        #(10 - $time % 10);
    endtask
    // let scl go, wait out any stretch, then a high phase
    task automatic rise;
        int n;
        n = 0;
        scl_lo = 1'h0;
        while (scl !== 1'h1 && n < 5000) begin
            #10;
            n++;
        end
        if (n >= 5000) stuck++;
        #(2 * Q);
    endtask
    // data set in low phase, read at end of high
    task automatic bit_io(input logic b, output logic s);
        #Q;
        sda_lo = !b;
        #Q;
        rise();
        s = sda;
        scl_lo = 1'h1;
    endtask
    // sda falls while scl high
    task automatic start;
        align();
        sda_lo = 1'h1;
        #(2 * Q);
        scl_lo = 1'h1;
    endtask
    // sda rises while scl high
    task automatic stop;
        align();
        #Q;
        sda_lo = 1'h1;
        #Q;
        rise();
        sda_lo = 1'h0;
        #(4 * Q);
    endtask
    // byte out msb first, ack bit in
    task automatic wr(input logic [7:0] b, output logic ack);
        logic s;
        align();
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'h1, ack);
    endtask
    // byte in msb first, ack bit out
    task automatic rd(output logic [7:0] b, input logic ack);
        logic s;
        align();
        for (int i = 7; i >= 0; i--) bit_io(1'h1, b[i]);
        bit_io(ack, s);
    endtask
endmodule

// *** i2c_slave_serial_port_bench.sv ***
/* bench for the two-wire slave port: bus tasks, note queue, checks.
   assumes the checker and master model are compiled first. */
`include "i2c_slave_defines.vh"
`define CHECK(e, g, nm) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module i2c_slave_serial_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [31:0] v; logic [31:0] m; string n;} note_t;
    localparam int TO_UNIT = 20; // short timeout unit
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic mclk = 1'h0;
    logic reset_n = 1'h0;
    logic hsel = 1'h0;
    logic [11:0] haddr = 12'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, scl_oe, sda_oe, serial_irq, scl_lo, sda_lo;
    wire scl = !(scl_oe || scl_lo); // pulled up
    wire sda = !(sda_oe || sda_lo); // pulled up
    logic rd_phase = 1'h0; // read data phase open
    logic [31:0] res = 32'h0; // latest pin or master result
    event res_ev;
    note_t q[$]; // expectations, oldest first
    int bad_count = 0;
    int tests_run = 0;
    int seed = 32'hafb231fd;
    logic [6:0] own; // own address
    logic [7:0] d [4]; // data bytes
    logic [7:0] v;
    logic a;
    logic [7:0] modes [2] = '{8'hA2, 8'hC0}; // wrong mode, disabled
    always #25 mclk = ~mclk;
    i2c_slave_serial_port #(.TO_UNIT(TO_UNIT)) i_dut (
        .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl),
        .scl_oe(scl_oe), .sda_in(sda), .sda_oe(sda_oe), .serial_irq(serial_irq));
    i2c_bus_master u_master (.scl(scl), .sda(sda), .scl_lo(scl_lo), .sda_lo(sda_lo));
    ////////////////////////////////////////
    // compare read data and results against the oldest note
    always @(posedge mclk) begin
        note_t x;
        if (rd_phase) begin
            x = q.pop_front();
            `CHECK(x.v, hrdata & x.m, x.n)
        end
    end
    always @(res_ev) begin
        note_t x;
        x = q.pop_front();
        `CHECK(x.v, res & x.m, x.n)
    end
    task automatic complete_run;
        bad_count += u_master.stuck;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'h1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            complete_run();
        end
    endtask
    // one single ahb transfer
    task automatic bus(input logic [11:0] ad, input logic wr, input logic [7:0] wd);
        @(posedge mclk);
        haddr <= ad;
        hwrite <= wr;
        hsel <= 1'h1;
        htrans <= 2'h2;
        wait_rdy();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        rd_phase <= !wr;
        wait_rdy();
        rd_phase <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] ev, input logic [31:0] em);
        q.push_back('{ev & em, em, $sformatf("reg %h", ad)});
        bus(ad, 1'h0, 8'h0);
    endtask
    task automatic mres(input logic [31:0] got, input logic [31:0] ev, input string nm);
        q.push_back('{ev, ALL, nm});
        res = got;
        ->res_ev;
        #1;
    endtask
    ////////////////////////////////////////
    initial begin
        own = $random(seed);
        foreach (d[i]) d[i] = $random(seed);
        repeat (12) @(posedge mclk);
        reset_n <= 1'h1;
        // reset values, unmapped place, own address bit 0
        rd(`ADDR_MODE_CTRL, 8'hE0, ALL);
        rd(`ADDR_STATUS_CTRL, 8'h81, ALL);
        rd(`ADDR_OWN_ADDR, 8'h00, ALL);
        rd(`ADDR_TIMEOUT_CTRL, 8'h00, ALL);
        rd(12'h020, 8'h00, ALL);
        bus(`ADDR_OWN_ADDR, 1'h1, 8'hFF);
        rd(`ADDR_OWN_ADDR, 8'hFE, ALL);
        bus(`ADDR_OWN_ADDR, 1'h1, {own, 1'h0});
        bus(`ADDR_STATUS_CTRL, 1'h1, 8'h18);
        // wrong mode or disabled: no acknowledge
        foreach (modes[i]) begin
            bus(`ADDR_MODE_CTRL, 1'h1, modes[i]);
            u_master.start();
            u_master.wr({own, 1'h0}, a);
            mres(a, 1'h1, "off ack");
            u_master.stop();
        end
        bus(`ADDR_MODE_CTRL, 1'h1, 8'hC2);
        rd(`ADDR_STATUS_CTRL, 8'h99, ALL);
        bus(`ADDR_STATUS_CTRL, 1'h1, 8'h00);
        // other address: no acknowledge, no match
        u_master.start();
        u_master.wr({own ^ 7'h01, 1'h0}, a);
        mres(a, 1'h1, "other ack");
        rd(`ADDR_STATUS_CTRL, 8'h20, 8'h60);
        u_master.stop();
        // master writes: ack, stretch, ack out bit decides
        u_master.start();
        u_master.wr({own, 1'h0}, a);
        mres(a, 1'h0, "addr ack");
        repeat (20) @(posedge mclk);
        mres(scl_oe, 1'h1, "stretch");
        rd(`ADDR_STATUS_CTRL, 8'h60, 8'h64);
        rd(`ADDR_SHIFT_DATA, 8'h00, 8'h00);
        u_master.wr(d[0], a);
        mres(a, 1'h0, "data ack");
        rd(`ADDR_STATUS_CTRL, 8'h80, 8'h80);
        rd(`ADDR_SHIFT_DATA, d[0], ALL);
        bus(`ADDR_STATUS_CTRL, 1'h1, 8'h08);
        u_master.wr(d[1], a);
        mres(a, 1'h1, "data nack");
        rd(`ADDR_SHIFT_DATA, d[1], ALL);
        u_master.stop();
        repeat (10) @(posedge mclk);
        rd(`ADDR_STATUS_CTRL, 8'h00, 8'h20);
        // master reads: ack then nack ends the send
        u_master.start();
        u_master.wr({own, 1'h1}, a);
        mres(a, 1'h0, "read addr ack");
        rd(`ADDR_STATUS_CTRL, 8'h64, 8'h64);
        bus(`ADDR_STATUS_CTRL, 1'h1, 8'h10);
        bus(`ADDR_SHIFT_DATA, 1'h1, d[2]);
        u_master.rd(v, 1'h0);
        mres(v, d[2], "sent byte");
        rd(`ADDR_STATUS_CTRL, 8'h00, 8'h01);
        bus(`ADDR_SHIFT_DATA, 1'h1, d[3]);
        u_master.rd(v, 1'h1);
        mres(v, d[3], "last byte");
        rd(`ADDR_STATUS_CTRL, 8'h01, 8'h01);
        repeat (20) @(posedge mclk);
        mres(sda_oe, 1'h0, "sda released");
        u_master.stop();
        // clock held too long: timeout
        bus(`ADDR_TIMEOUT_CTRL, 1'h1, 8'h80);
        u_master.start();
        u_master.wr({own, 1'h0}, a);
        repeat (5 * TO_UNIT) @(posedge mclk);
        rd(`ADDR_TIMEOUT_CTRL, 8'h40, 8'hC0);
        rd(`ADDR_STATUS_CTRL, 8'h81, ALL);
        u_master.stop();
        // clockless receive: no stretch, byte still taken and acknowledged
        bus(`ADDR_STATUS_CTRL, 1'h1, 8'h02);
        u_master.start();
        u_master.wr({own, 1'h0}, a);
        repeat (20) @(posedge mclk);
        mres(scl_oe, 1'h0, "no stretch");
        u_master.wr(d[3], a);
        mres(a, 1'h0, "clockless ack");
        rd(`ADDR_SHIFT_DATA, d[3], ALL);
        u_master.stop();
        complete_run();
    end
endmodule
bind i2c_slave_serial_port i2c_slave_port_sva #(.TO_UNIT(TO_UNIT)) u_sva (
    .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .scl_in(scl_in), .scl_oe(scl_oe), .sda_in(sda_in),
    .sda_oe(sda_oe), .serial_irq(serial_irq));
